// ===== rtl/END_UNUSED.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== rtl/prbs7_word.v
`timescale 1ns/1ps
`default_nettype none
`include "prbs_bist_defs.vh"

// Advances a PRBS7 (x^7 + x^6 + 1) register by one whole payload word.
// The first bit produced lands in word_o[23], the last in word_o[0], so the
// register after the word equals word_o[6:0]; a checker can reseed from it.
module prbs7_word
(
	input  wire [`PRBS_W-1:0]    state_i,
	output reg  [`PAYLOAD_W-1:0] word_o,
	output wire [`PRBS_W-1:0]    state_nxt_o
);

	reg [`PRBS_W-1:0] s;
	reg               fb;
	integer           i;

	always @*
	begin
		s = state_i;
		fb = 1'b0;
		word_o = {`PAYLOAD_W{1'b0}};
		for (i = `PAYLOAD_W - 1; i >= 0; i = i - 1)
		begin
			fb = s[6] ^ s[5];
			s = {s[5:0], fb};
			word_o[i] = fb;
		end
	end

	assign state_nxt_o = word_o[`PRBS_W-1:0];

endmodule // prbs7_word

`default_nettype wire

// ===== rtl/prbs_bist_defs.vh
`ifndef PRBS_BIST_DEFS_VH
`define PRBS_BIST_DEFS_VH

// Register map of the plain register port
`define REG_ADDR_W          4
`define REG_DATA_W          16
`define REG_CTRL            4'h0
`define REG_STATUS          4'h1
`define REG_ERRCNT          4'h2
`define REG_LINK_PERIOD     4'h3

// Control register fields
`define CTRL_RESTART_BIT    0
`define CTRL_CLKBIT_CHK_BIT 1
`define CTRL_RESET_VAL      16'h0002

// Status register fields
`define STAT_VERDICT_BIT    0
`define STAT_LOCK_BIT       1
`define STAT_CHECKING_BIT   2
`define STAT_SYNCED_BIT     3
`define STAT_TEST_CMD_BIT   4
`define STAT_HOLDING_BIT    5

// Link word layout
`define PAYLOAD_W           24
`define CTRL_W              3
`define PRBS_W              7
`define PRBS_SEED           7'h7F

// Checker and lock timing
`define SYNC_WORDS          2'h2
`define LOCK_GOOD_WORDS     4'h4
`define CLK_PERIOD_NS       40
`define LOCK_TIMEOUT_NS     2000
`define LOCK_TIMEOUT_CYC    ((`LOCK_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== rtl/serial_link_prbs_bist.v
`timescale 1ns/1ps
`default_nettype none
`include "prbs_bist_defs.vh"

module serial_link_prbs_bist
(
	input  wire                   clk_i,
	input  wire                   reset_n_i,
	input  wire                   power_down_i,
	input  wire                   ser_self_test_enable_i,
	input  wire                   des_self_test_enable_i,
	input  wire                   parallel_input_clock_i,
	input  wire [`PAYLOAD_W-1:0]  par_data_i,
	input  wire [`CTRL_W-1:0]     par_ctrl_i,
	output reg                    link_clock_o,
	output reg  [`PAYLOAD_W-1:0]  link_data_o,
	output reg  [`CTRL_W-1:0]     link_ctrl_o,
	output reg                    link_test_cmd_o,
	output reg                    embedded_clock_bit_high_o,
	output reg                    embedded_clock_bit_low_o,
	input  wire                   rx_link_clock_i,
	input  wire [`PAYLOAD_W-1:0]  rx_data_i,
	input  wire [`CTRL_W-1:0]     rx_ctrl_i,
	input  wire                   rx_test_cmd_i,
	input  wire                   rx_embedded_clock_bit_high_i,
	input  wire                   rx_embedded_clock_bit_low_i,
	output reg  [`PAYLOAD_W-1:0]  out_data_o,
	output reg  [`CTRL_W-1:0]     out_ctrl_o,
	output reg                    out_oe_n_o,
	output reg                    result_o,
	output reg                    lock_o,
	input  wire [`REG_ADDR_W-1:0] reg_addr_i,
	input  wire [`REG_DATA_W-1:0] reg_wdata_i,
	input  wire                   reg_wr_i,
	input  wire                   reg_rd_i,
	output reg  [`REG_DATA_W-1:0] reg_rdata_o
);

	localparam ST_IDLE  = 2'h0;
	localparam ST_CHECK = 2'h1;
	localparam ST_HOLD  = 2'h2;
	localparam RXW      = `PAYLOAD_W + `CTRL_W + 3;
	localparam TXW      = `PAYLOAD_W + `CTRL_W + 1;
	localparam integer LOCK_TO_CYC = `LOCK_TIMEOUT_CYC;
	localparam [7:0]   LOCK_TO     = LOCK_TO_CYC[7:0];

	// Two-flop synchronisers on every link and mode pin, not on reset or the register port; stage 1 is read only by stage 2.
	// Bus and strobe are synchronised alike, so the link clock must be slow
	// against clk_i for the sampled word to be settled at its edge.
	reg [4:0]     ctl_s1_r;
	reg [4:0]     ctl_s2_r;
	reg [TXW-1:0] tx_s1_r;
	reg [TXW-1:0] tx_s2_r;
	reg [RXW-1:0] rx_s1_r;
	reg [RXW-1:0] rx_s2_r;
	reg           par_clk_d_r;
	reg           rx_clk_d_r;

	wire pwr_down   = ctl_s2_r[0];
	wire ser_en     = ctl_s2_r[1];
	wire des_en     = ctl_s2_r[2];
	wire par_clk    = ctl_s2_r[3];
	wire rx_clk     = ctl_s2_r[4];
	wire par_rise   = par_clk & ~par_clk_d_r;
	wire rx_rise    = rx_clk & ~rx_clk_d_r;
	wire [`PAYLOAD_W-1:0] rx_word = rx_s2_r[RXW-1 -: `PAYLOAD_W];
	wire [`CTRL_W-1:0]    rx_ctl  = rx_s2_r[5:3];
	wire rx_cmd     = rx_s2_r[2];
	wire rx_cb_high = rx_s2_r[1];
	wire rx_cb_low  = rx_s2_r[0];

	always @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			ctl_s1_r    <= 5'h00;
			ctl_s2_r    <= 5'h00;
			tx_s1_r     <= {TXW{1'b0}};
			tx_s2_r     <= {TXW{1'b0}};
			rx_s1_r     <= {RXW{1'b0}};
			rx_s2_r     <= {RXW{1'b0}};
			par_clk_d_r <= 1'b0;
			rx_clk_d_r  <= 1'b0;
		end
		else
		begin
			ctl_s1_r    <= {rx_link_clock_i, parallel_input_clock_i, des_self_test_enable_i,
			                ser_self_test_enable_i, power_down_i};
			ctl_s2_r    <= ctl_s1_r;
			tx_s1_r     <= {par_data_i, par_ctrl_i, 1'b0};
			tx_s2_r     <= tx_s1_r;
			rx_s1_r     <= {rx_data_i, rx_ctrl_i, rx_test_cmd_i,
			                rx_embedded_clock_bit_high_i, rx_embedded_clock_bit_low_i};
			rx_s2_r     <= rx_s1_r;
			par_clk_d_r <= par_clk;
			rx_clk_d_r  <= rx_clk;
		end
	end

	// Serializer: PRBS words are cut from the parallel clock, so no word moves without it.
	reg  [`PRBS_W-1:0]    gen_state_r;
	wire [`PAYLOAD_W-1:0] gen_word;
	wire [`PRBS_W-1:0]    gen_state_nxt;

	prbs7_word u_gen
	(
		.state_i     (gen_state_r),
		.word_o      (gen_word),
		.state_nxt_o (gen_state_nxt)
	);

	always @(posedge clk_i)
	begin
		if (!reset_n_i || pwr_down)
		begin
			gen_state_r               <= `PRBS_SEED;
			link_data_o               <= {`PAYLOAD_W{1'b0}};
			link_ctrl_o               <= {`CTRL_W{1'b0}};
			link_test_cmd_o           <= 1'b0;
			link_clock_o              <= 1'b0;
			embedded_clock_bit_high_o <= 1'b0;
			embedded_clock_bit_low_o  <= 1'b0;
		end
		else
		begin
			// Clock rises one cycle after the word so the far end samples settled data
			link_clock_o              <= par_clk_d_r;
			embedded_clock_bit_high_o <= 1'b1;
			embedded_clock_bit_low_o  <= 1'b0;
			if (par_rise)
			begin
				if (ser_en)
				begin
					link_data_o     <= gen_word;
					link_ctrl_o     <= {`CTRL_W{1'b0}};
					link_test_cmd_o <= 1'b1;
					gen_state_r     <= gen_state_nxt;
				end
				else
				begin
					link_data_o     <= tx_s2_r[TXW-1 -: `PAYLOAD_W];
					link_ctrl_o     <= tx_s2_r[`CTRL_W:1];
					link_test_cmd_o <= 1'b0;
					gen_state_r     <= `PRBS_SEED;
				end
			end
		end
	end

	// Register file
	reg  [`REG_DATA_W-1:0] ctrl_r;
	reg  [`REG_DATA_W-1:0] err_cnt_r;
	reg  [7:0]             period_r;
	wire                   restart = reg_wr_i && (reg_addr_i == `REG_CTRL) &&
	                                 reg_wdata_i[`CTRL_RESTART_BIT];

	// Lock: embedded clock bits checked per word, plus a watchdog on the link clock
	reg  [7:0] idle_cnt_r;
	reg  [3:0] good_cnt_r;
	wire       cb_bad = ctrl_r[`CTRL_CLKBIT_CHK_BIT] && !(rx_cb_high && !rx_cb_low);

	always @(posedge clk_i)
	begin
		if (!reset_n_i || pwr_down)
		begin
			idle_cnt_r <= 8'h00;
			good_cnt_r <= 4'h0;
			lock_o     <= 1'b0;
		end
		else if (rx_rise)
		begin
			idle_cnt_r <= 8'h00;
			if (cb_bad)
			begin
				good_cnt_r <= 4'h0;
				lock_o     <= 1'b0;
			end
			else if (good_cnt_r == `LOCK_GOOD_WORDS)
				lock_o     <= 1'b1;
			else
				good_cnt_r <= good_cnt_r + 4'h1;
		end
		else if (idle_cnt_r == LOCK_TO)
		begin
			good_cnt_r <= 4'h0;
			lock_o     <= 1'b0;
		end
		else
			idle_cnt_r <= idle_cnt_r + 8'h01;
	end

	// Deserializer checker
	reg  [1:0]            state_r;
	reg  [1:0]            sync_cnt_r;
	reg  [`PRBS_W-1:0]    seed_r;
	reg                   err_seen_r;
	reg                   cmd_seen_r;
	reg  [7:0]            per_cnt_r;
	reg  [6:0]            low_cnt_r;
	wire [`PAYLOAD_W-1:0] exp_word;
	wire [`PRBS_W-1:0]    exp_state_nxt;
	wire                  synced = (sync_cnt_r == `SYNC_WORDS);
	wire                  word_bad = (exp_word != rx_word);

	prbs7_word u_chk
	(
		.state_i     (seed_r),
		.word_o      (exp_word),
		.state_nxt_o (exp_state_nxt)
	);

	always @(posedge clk_i)
	begin
		if (!reset_n_i || pwr_down || restart)
		begin
			state_r    <= ST_IDLE;
			sync_cnt_r <= 2'h0;
			seed_r     <= `PRBS_SEED;
			err_seen_r <= 1'b0;
			err_cnt_r  <= {`REG_DATA_W{1'b0}};
			low_cnt_r  <= 7'h00;
		end
		else
		begin
			if (low_cnt_r != 7'h00)
				low_cnt_r <= low_cnt_r - 7'h01;
			// Once synced the checker runs on its own sequence, so one bad word counts once
			if (rx_rise && rx_cmd && (state_r == ST_CHECK) && synced)
				seed_r <= exp_state_nxt;
			else if (rx_rise && rx_cmd)
				seed_r <= rx_word[`PRBS_W-1:0];
			case (state_r)
				ST_IDLE, ST_HOLD:
				begin
					if (des_en)
					begin
						state_r    <= ST_CHECK;
						sync_cnt_r <= 2'h0;
						err_seen_r <= 1'b0;
						err_cnt_r  <= {`REG_DATA_W{1'b0}};
					end
				end
				ST_CHECK:
				begin
					if (!des_en)
						state_r <= ST_HOLD;
					else if (rx_rise && rx_cmd)
					begin
						if (!synced)
							sync_cnt_r <= word_bad ? 2'h0 : sync_cnt_r + 2'h1;
						else if (word_bad)
						begin
							// Any mismatch in a 24-bit word is 1 to 24 bit errors
							err_seen_r <= 1'b1;
							// At least one cycle even before a period has been measured
							low_cnt_r  <= (period_r[7:1] == 7'h00) ? 7'h01 : period_r[7:1];
							if (err_cnt_r != {`REG_DATA_W{1'b1}})
								err_cnt_r <= err_cnt_r + 1'b1;
						end
					end
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// Link clock period, measured so the error pulse tracks the real rate
	always @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			per_cnt_r <= 8'h00;
			period_r  <= 8'h00;
		end
		else if (rx_rise)
		begin
			per_cnt_r <= 8'h01;
			period_r  <= per_cnt_r;
		end
		else if (per_cnt_r != 8'hFF)
			per_cnt_r <= per_cnt_r + 8'h01;
	end

	// Result pin and parallel outputs
	always @(posedge clk_i)
	begin
		if (!reset_n_i || pwr_down)
		begin
			result_o   <= 1'b1;
			out_oe_n_o <= 1'b1;
			cmd_seen_r <= 1'b0;
			out_data_o <= {`PAYLOAD_W{1'b0}};
			out_ctrl_o <= {`CTRL_W{1'b0}};
		end
		else
		begin
			if (state_r == ST_HOLD)
				result_o <= ~err_seen_r;
			else if (state_r == ST_CHECK)
				result_o <= (low_cnt_r == 7'h00);
			else
				result_o <= 1'b1;
			if (rx_rise)
			begin
				cmd_seen_r <= rx_cmd;
				if (!rx_cmd)
				begin
					out_data_o <= rx_word;
					out_ctrl_o <= rx_ctl;
				end
			end
			// Outputs stay off until lock, and while the test command is seen
			out_oe_n_o <= !lock_o || cmd_seen_r;
		end
	end

	always @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			ctrl_r      <= `CTRL_RESET_VAL;
			reg_rdata_o <= {`REG_DATA_W{1'b0}};
		end
		else
		begin
			if (reg_wr_i && (reg_addr_i == `REG_CTRL))
				ctrl_r <= reg_wdata_i & (`REG_DATA_W'h1 << `CTRL_CLKBIT_CHK_BIT);
			reg_rdata_o <= {`REG_DATA_W{1'b0}};
			if (reg_rd_i)
			begin
				case (reg_addr_i)
					`REG_CTRL:        reg_rdata_o <= ctrl_r;
					`REG_STATUS:      reg_rdata_o <= {10'h000, (state_r == ST_HOLD), cmd_seen_r,
					                                  synced, (state_r == ST_CHECK), lock_o,
					                                  ~err_seen_r};
					`REG_ERRCNT:      reg_rdata_o <= err_cnt_r;
					`REG_LINK_PERIOD: reg_rdata_o <= {8'h00, period_r};
					default:          reg_rdata_o <= {`REG_DATA_W{1'b0}};
				endcase
			end
		end
	end

endmodule // serial_link_prbs_bist

`default_nettype wire

// ===== verif/bist_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "prbs_bist_defs.vh"
module bist_checker
(
	input wire logic                   clk_i,
	input wire logic                   reset_n_i,
	input wire logic                   power_down_i,
	input wire logic                   ser_self_test_enable_i,
	input wire logic                   des_self_test_enable_i,
	input wire logic [`CTRL_W-1:0]     link_ctrl_o,
	input wire logic                   link_test_cmd_o,
	input wire logic                   rx_link_clock_i,
	input wire logic                   rx_test_cmd_i,
	input wire logic                   rx_embedded_clock_bit_high_i,
	input wire logic                   rx_embedded_clock_bit_low_i,
	input wire logic                   out_oe_n_o,
	input wire logic                   result_o,
	input wire logic                   lock_o,
	input wire logic [`REG_ADDR_W-1:0] reg_addr_i,
	input wire logic [`REG_DATA_W-1:0] reg_wdata_i,
	input wire logic                   reg_wr_i,
	input wire logic                   reg_rd_i,
	input wire logic [`REG_DATA_W-1:0] reg_rdata_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// Mirrors the clock-bit check enable, which is on out of reset
	logic clkbit_chk_r;
	always @(posedge clk_i)
		if (!reset_n_i)
			clkbit_chk_r <= 1'b1;
		else if (reg_wr_i && (reg_addr_i == `REG_CTRL))
			clkbit_chk_r <= reg_wdata_i[`CTRL_CLKBIT_CHK_BIT];
	// A 320 ns word gives a pulse of four cycles
	sequence low_pulse;
		!result_o [*4] ##1 result_o;
	endsequence
	sequence rx_word;
		$rose(rx_link_clock_i);
	endsequence
	a_pd_clears: assert property (
		power_down_i [*4] |=> result_o && !lock_o)
		else $error("power down left result or lock set");
	a_test_ctrl_zero: assert property (
		link_test_cmd_o |-> link_ctrl_o == 3'h0)
		else $error("control bits sent in a test word");
	a_cmd_after_enable: assert property (
		$rose(link_test_cmd_o) |-> $past(ser_self_test_enable_i, 3))
		else $error("test word without serializer enable");
	a_test_outputs_off: assert property (
		rx_word and rx_test_cmd_i |-> ##[1:6] out_oe_n_o)
		else $error("parallel outputs left on in test");
	a_lock_bad_bits: assert property (
		rx_word and (clkbit_chk_r && rx_embedded_clock_bit_high_i == rx_embedded_clock_bit_low_i)
		|-> ##[1:6] !lock_o)
		else $error("lock kept on bad clock bits");
	a_verdict_held: assert property (
		(!des_self_test_enable_i && !power_down_i && !reg_wr_i) [*6] |=> $stable(result_o))
		else $error("verdict moved while idle");
	a_pulse_width: assert property (
		$fell(result_o) && des_self_test_enable_i |-> low_pulse)
		else $error("error pulse of wrong width");
	a_rdata_idle: assert property (
		!reg_rd_i |=> reg_rdata_o == 16'h0000)
		else $error("read data outside read slot");
endmodule // bist_checker
bind serial_link_prbs_bist bist_checker u_bist_checker
(
	.clk_i, .reset_n_i, .power_down_i, .ser_self_test_enable_i, .des_self_test_enable_i,
	.link_ctrl_o, .link_test_cmd_o, .rx_link_clock_i, .rx_test_cmd_i,
	.rx_embedded_clock_bit_high_i, .rx_embedded_clock_bit_low_i, .out_oe_n_o, .result_o,
	.lock_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o
);
`default_nettype wire

// ===== verif/link_partner.sv
`timescale 1ns/1ps
`default_nettype none
`include "prbs_bist_defs.vh"
module link_partner
(
	input  wire logic                  link_clock_i,
	input  wire logic [`PAYLOAD_W-1:0] link_data_i,
	input  wire logic [`CTRL_W-1:0]    link_ctrl_i,
	input  wire logic                  link_test_cmd_i,
	input  wire logic                  emb_high_i,
	input  wire logic                  emb_low_i,
	input  wire logic                  inject_err_i,
	input  wire logic                  bad_bits_i,
	output var  logic                  rx_clock_o,
	output var  logic [`PAYLOAD_W-1:0] rx_data_o,
	output var  logic [`CTRL_W-1:0]    rx_ctrl_o,
	output var  logic                  rx_test_cmd_o,
	output var  logic                  rx_high_o,
	output var  logic                  rx_low_o
);
	initial {rx_clock_o, rx_data_o, rx_ctrl_o, rx_test_cmd_o, rx_high_o, rx_low_o} = '0;
	// Fields settle well before the recovered edge, so a word is never caught moving
	always @(posedge link_clock_i)
	begin
		rx_data_o     <= link_data_i ^ {{(`PAYLOAD_W-1){1'b0}}, inject_err_i};
		rx_ctrl_o     <= link_ctrl_i;
		rx_test_cmd_o <= link_test_cmd_i;
		rx_high_o     <= emb_high_i & ~bad_bits_i;
		rx_low_o      <= emb_low_i;
	end
	// Odd delay keeps the recovered clock out of phase with the system clock
	always @(link_clock_i)
		rx_clock_o <= #93 link_clock_i;
endmodule // link_partner
`default_nettype wire

// ===== verif/serial_link_prbs_bist_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "prbs_bist_defs.vh"
module serial_link_prbs_bist_test;
	logic clk_i = 1'b0, reset_n_i = 1'b0, power_down_i = 1'b0, parallel_input_clock_i = 1'b0;
	logic ser_self_test_enable_i = 1'b0, des_self_test_enable_i = 1'b0;
	logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, inject_err = 1'b0, bad_bits = 1'b0;
	logic [`PAYLOAD_W-1:0]  par_data_i = 24'hA5C3E1, link_data_o, rx_data_i, out_data_o;
	logic [`CTRL_W-1:0]     par_ctrl_i = 3'h5, link_ctrl_o, rx_ctrl_i, out_ctrl_o;
	logic [`REG_ADDR_W-1:0] reg_addr_i = 4'h0;
	logic [`REG_DATA_W-1:0] reg_wdata_i = 16'h0000, reg_rdata_o;
	logic link_clock_o, link_test_cmd_o, embedded_clock_bit_high_o, embedded_clock_bit_low_o;
	logic rx_link_clock_i, rx_test_cmd_i, rx_embedded_clock_bit_high_i;
	logic rx_embedded_clock_bit_low_i, out_oe_n_o, result_o, lock_o;
	int err_count = 0, samples_checked = 0, pulses = 0;

	serial_link_prbs_bist DUT
	(
		.clk_i, .reset_n_i, .power_down_i, .ser_self_test_enable_i, .des_self_test_enable_i,
		.parallel_input_clock_i, .par_data_i, .par_ctrl_i, .link_clock_o, .link_data_o,
		.link_ctrl_o, .link_test_cmd_o, .embedded_clock_bit_high_o, .embedded_clock_bit_low_o,
		.rx_link_clock_i, .rx_data_i, .rx_ctrl_i, .rx_test_cmd_i, .rx_embedded_clock_bit_high_i,
		.rx_embedded_clock_bit_low_i, .out_data_o, .out_ctrl_o, .out_oe_n_o, .result_o, .lock_o,
		.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o
	);
	link_partner u_partner
	(
		.link_clock_i(link_clock_o), .link_data_i(link_data_o), .link_ctrl_i(link_ctrl_o),
		.link_test_cmd_i(link_test_cmd_o), .emb_high_i(embedded_clock_bit_high_o),
		.emb_low_i(embedded_clock_bit_low_o), .inject_err_i(inject_err), .bad_bits_i(bad_bits),
		.rx_clock_o(rx_link_clock_i), .rx_data_o(rx_data_i), .rx_ctrl_o(rx_ctrl_i),
		.rx_test_cmd_o(rx_test_cmd_i), .rx_high_o(rx_embedded_clock_bit_high_i),
		.rx_low_o(rx_embedded_clock_bit_low_i)
	);

	initial forever #20 clk_i = ~clk_i;
	// Kept running through every test, since the pattern is made from it
	initial forever
	begin
		repeat (4) @(posedge clk_i);
		parallel_input_clock_i <= ~parallel_input_clock_i;
	end
	always @(negedge result_o)
		if (des_self_test_enable_i)
			pulses++;

	task conclude;
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic cmp(input logic [`PAYLOAD_W-1:0] got, input logic [`PAYLOAD_W-1:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 cmp({8'h00, reg_rdata_o}, {8'h00, exp});
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask

	task automatic wait_lock;
		int i;
		for (i = 0; i < 400 && lock_o !== 1'b1; i++)
			@(negedge clk_i);
		if (lock_o !== 1'b1)
		begin
			err_count++;
			conclude();
		end
	endtask

	// Bounded wait for a rising link clock, seen one system clock late
	task automatic link_edge;
		int i;
		for (i = 0; i < 20 && link_clock_o !== 1'b0; i++)
			@(posedge clk_i);
		for (i = 0; i < 20 && link_clock_o !== 1'b1; i++)
			@(posedge clk_i);
		if (link_clock_o !== 1'b1)
		begin
			err_count++;
			conclude();
		end
	endtask

	task automatic run_test(input logic inj);
		@(posedge clk_i);
		ser_self_test_enable_i <= 1'b1;
		tick(40);
		cmp(link_test_cmd_o, 1'b1);
		cmp(link_ctrl_o, 3'h0);
		cmp(out_oe_n_o, 1'b1);
		@(posedge clk_i);
		des_self_test_enable_i <= 1'b1;
		pulses = 0;
		tick(100);
		cmp(result_o, 1'b1);
		if (inj)
		begin
			link_edge();
			inject_err <= 1'b1;
			link_edge();
			inject_err <= 1'b0;
		end
		repeat (100) @(posedge clk_i);
		des_self_test_enable_i <= 1'b0;
		tick(10);
		cmp(24'(pulses), inj ? 24'h000001 : 24'h000000);
		cmp(result_o, !inj);
		rd_chk(`REG_ERRCNT, inj ? 16'h0001 : 16'h0000);
		rd_chk(`REG_STATUS, inj ? 16'h003A : 16'h003B);
		tick(40);
		cmp(result_o, !inj);
	endtask

	initial
	begin
		repeat (12) @(posedge clk_i);
		reset_n_i <= 1'b1;
		tick(0);
		cmp(result_o, 1'b1);
		cmp(lock_o, 1'b0);
		rd_chk(`REG_CTRL, `CTRL_RESET_VAL);
		rd_chk(4'hF, 16'h0000);
		wait_lock();
		tick(40);
		cmp(out_data_o, par_data_i);
		cmp(out_ctrl_o, par_ctrl_i);
		rd_chk(`REG_LINK_PERIOD, 16'h0008);
		cmp({embedded_clock_bit_high_o, embedded_clock_bit_low_o}, 2'h2);
		run_test(1'b1);
		run_test(1'b0);
		run_test(1'b1);
		reg_write(`REG_CTRL, 16'h0003);
		tick(4);
		cmp(result_o, 1'b1);
		rd_chk(`REG_CTRL, `CTRL_RESET_VAL);
		run_test(1'b1);
		@(posedge clk_i);
		power_down_i <= 1'b1;
		tick(10);
		cmp(result_o, 1'b1);
		cmp(lock_o, 1'b0);
		cmp({embedded_clock_bit_high_o, embedded_clock_bit_low_o}, 2'h0);
		@(posedge clk_i);
		power_down_i <= 1'b0;
		ser_self_test_enable_i <= 1'b0;
		wait_lock();
		bad_bits <= 1'b1;
		tick(40);
		cmp(lock_o, 1'b0);
		bad_bits <= 1'b0;
		wait_lock();
		tick(40);
		cmp(out_data_o, par_data_i);
		cmp(out_oe_n_o, 1'b0);
		reg_write(`REG_CTRL, 16'h0000);
		bad_bits <= 1'b1;
		tick(40);
		cmp(lock_o, 1'b1);
		bad_bits <= 1'b0;
		tick(10);
		reg_write(`REG_CTRL, `CTRL_RESET_VAL);
		rd_chk(`REG_CTRL, `CTRL_RESET_VAL);
		conclude();
	end
endmodule // serial_link_prbs_bist_test
`default_nettype wire
